/* File: hdl/phase_shedding_startup_control.sv */
// start-up sequencing, phase shedding and phase clock rotation for a
// dual-output multiphase regulator controller
// assumes async pin levels, one master one-shot per output and a register
// master on mclk that never issues both strobes at once
//
// How it works
// [RULE1] diode emulation only in power states two, three
// [RULE2] emulation on first channels 1-2, second channel 1
// [RULE3] no regulation until all three supplies ok
// [RULE4] start-up begins when enable sampled high
// [RULE5] dac steps from zero to boot voltage
// [RULE6] power good rises as ramp begins
// [RULE7] alert goes low when ramp reaches boot
// [RULE8] enable tied high starts right after supply ok
// [RULE9] low side off until output above 400mV
// [RULE10] sense pin strapped high disables that phase
// [RULE11] board disables phases from highest number down
// [RULE12] four-phase first output shedding and overcurrent table
// [RULE13] three-phase first output shedding and overcurrent table
// [RULE14] two-phase first output runs phase 1 later
// [RULE15] one-phase first output keeps one overcurrent limit
// [RULE16] three-phase second output shedding and overcurrent table
// [RULE17] two-phase second output runs phase 1 later
// [RULE18] one-phase second output keeps one overcurrent limit
// [RULE19] power state written at 32h drives shedding
// [RULE20] master clock pulses rotate among active phases
// [RULE21] output with phase 1 strapped high ignores bus
// [RULE22] conduction choice from second resistor, shared
// [RULE23] two-bit power state, reevaluated on every change
//
// The implementer's own choices: the strobed register port and the register offsets.
`timescale 1ns/1ps
module phase_shedding_startup_control
    import pss_pkg::*;
(
    // clock, reset, enable
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic ce,
    // bias supply comparators: above rising and above falling threshold
    input wire logic [2:0] por_rise_ok,
    input wire logic [2:0] por_fall_ok,
    // start-up pins
    input wire logic regulator_enable_input,
    input wire logic vout_above_400mv,
    input wire logic [DAC_W-1:0] boot_voltage,
    input wire logic second_program_resistor,
    // phase sense straps, high when strapped to the logic supply
    input wire logic [A_PH-1:0] a_phase_sense_pin,
    input wire logic [B_PH-1:0] b_phase_sense_pin,
    // master clock one-shots from the modulators
    input wire logic a_master_clk,
    input wire logic b_master_clk,
    // register port, bus_sel picks the output addressed
    input wire logic bus_sel,
    input wire logic [ADDR_W-1:0] bus_addr,
    input wire logic [DATA_W-1:0] bus_wdata,
    input wire logic bus_wr,
    input wire logic bus_rd,
    output logic [DATA_W-1:0] bus_rdata,
    output logic bus_ack,
    // start-up outputs
    output logic power_good_output,
    output logic alert_n,
    output logic [DAC_W-1:0] dac_code,
    output logic low_side_gate_en,
    // shedding outputs
    output logic [A_PH-1:0] a_phase_en,
    output logic [B_PH-1:0] b_phase_en,
    output logic [1:0] a_overcurrent_limit,
    output logic [1:0] b_overcurrent_limit,
    output logic [1:0] a_diode_emulation_mode,
    output logic b_diode_emulation_mode,
    // phase clocks
    output logic [A_PH-1:0] a_phase_clk,
    output logic [B_PH-1:0] b_phase_clk
);

    // ------------------------------------------------------------------
    // pin synchronisers
    // ------------------------------------------------------------------
    localparam int SYNC_W = 3 + 3 + 1 + 1 + DAC_W + 1 + A_PH + B_PH + 1 + 1;

    logic [SYNC_W-1:0] sync1_q;
    logic [SYNC_W-1:0] sync2_q;
    logic [2:0] rise_s;
    logic [2:0] fall_s;
    logic en_s;
    logic v400_s;
    logic [DAC_W-1:0] boot_s;
    logic dem_sel_s;
    logic [A_PH-1:0] a_strap_s;
    logic [B_PH-1:0] b_strap_s;
    logic a_mclk_s;
    logic b_mclk_s;

    // two flops on every pin; only the second one is read below
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else if (ce) begin
            sync1_q <= {por_rise_ok, por_fall_ok, regulator_enable_input,
                        vout_above_400mv, boot_voltage, second_program_resistor,
                        a_phase_sense_pin, b_phase_sense_pin, a_master_clk,
                        b_master_clk};
            sync2_q <= sync1_q;
        end
    end

    assign {rise_s, fall_s, en_s, v400_s, boot_s, dem_sel_s, a_strap_s, b_strap_s,
            a_mclk_s, b_mclk_s} = sync2_q;

    // ------------------------------------------------------------------
    // bias supervision
    // ------------------------------------------------------------------
    logic bias_ok_q;

    // up only when every supply passes its rising threshold, down only when
    // one falls under its lower threshold, so small dips do not trip it
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bias_ok_q <= 1'b0;
        end else if (ce) begin
            if (!(&fall_s)) begin
                bias_ok_q <= 1'b0; // [RULE3]
            end else if (&rise_s) begin
                bias_ok_q <= 1'b1; // [RULE3]
            end
        end
    end

    // ------------------------------------------------------------------
    // strap capture
    // ------------------------------------------------------------------
    seq_t seq_q;
    logic [2:0] a_cnt_q;
    logic [2:0] b_cnt_q;
    logic a_on_q;
    logic b_on_q;
    logic dem_sel_q;
    logic [DAC_W-1:0] boot_q;

    // straps are read once, as the supplies come good; a board that breaks
    // the highest-first order gets the count of the unbroken low run
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            a_cnt_q <= PH_ONE;
            b_cnt_q <= PH_ONE;
            a_on_q <= 1'b0;
            b_on_q <= 1'b0;
            dem_sel_q <= 1'b0;
            boot_q <= DAC_ZERO;
        end else if (ce && seq_q == SEQ_OFF && bias_ok_q) begin
            a_cnt_q <= a_strap_s[1] ? PH_ONE : a_strap_s[2] ? PH_TWO : // [RULE10] [RULE11]
                       a_strap_s[3] ? PH_THREE : PH_FOUR;
            b_cnt_q <= b_strap_s[1] ? PH_ONE : b_strap_s[2] ? PH_TWO : PH_THREE; // [RULE10]
            a_on_q <= !a_strap_s[0]; // [RULE21]
            b_on_q <= !b_strap_s[0]; // [RULE21]
            dem_sel_q <= dem_sel_s; // [RULE22]
            boot_q <= boot_s;
        end
    end

    // ------------------------------------------------------------------
    // start-up sequencer and soft-start dac
    // ------------------------------------------------------------------
    logic [SS_CNT_W-1:0] step_cnt_q;
    logic [DAC_W-1:0] dac_q;
    logic ramp_done;
    logic step_tick;

    assign step_tick = (step_cnt_q == SS_CNT_W'(SS_STEP_CYC - 1));
    assign ramp_done = (seq_q == SEQ_RAMP) && (dac_q == boot_q);

    // enable tied high simply passes the wait state on the next cycle
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            seq_q <= SEQ_OFF;
        end else if (ce) begin
            if (!bias_ok_q) begin
                seq_q <= SEQ_OFF; // [RULE3]
            end else begin
                unique case (seq_q)
                    SEQ_OFF: seq_q <= SEQ_WAIT_EN; // [RULE3]
                    SEQ_WAIT_EN: if (en_s) seq_q <= SEQ_RAMP; // [RULE4] [RULE8]
                    SEQ_RAMP: begin
                        if (!en_s) begin
                            seq_q <= SEQ_WAIT_EN;
                        end else if (ramp_done) begin
                            seq_q <= SEQ_RUN; // [RULE5]
                        end
                    end
                    SEQ_RUN: if (!en_s) seq_q <= SEQ_WAIT_EN;
                endcase
            end
        end
    end

    // dac counts up one code per step time from zero to the boot code
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            dac_q <= DAC_ZERO;
            step_cnt_q <= '0;
        end else if (ce) begin
            if (seq_q != SEQ_RAMP && seq_q != SEQ_RUN) begin
                dac_q <= DAC_ZERO; // [RULE5]
                step_cnt_q <= '0;
            end else if (seq_q == SEQ_RAMP && !ramp_done) begin
                step_cnt_q <= step_tick ? '0 : step_cnt_q + 1'b1;
                if (step_tick) begin
                    dac_q <= dac_q + DAC_STEP; // [RULE5]
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // power good, alert, low-side release
    // ------------------------------------------------------------------
    logic pg_q;
    logic alert_n_q;
    logic ls_q;
    logic status_rd;

    // power good comes with the first ramp cycle and stays while running
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            pg_q <= 1'b0;
        end else if (ce) begin
            pg_q <= (seq_q != SEQ_OFF) && en_s && bias_ok_q; // [RULE6]
        end
    end

    // alert stays low until software reads status; a new ramp end wins
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            alert_n_q <= 1'b1;
        end else if (ce) begin
            if (ramp_done && bias_ok_q && en_s) begin
                alert_n_q <= 1'b0; // [RULE7]
            end else if (status_rd) begin
                alert_n_q <= 1'b1;
            end
        end
    end

    // body diodes carry the ramp current until the output passes 400mV
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ls_q <= 1'b0;
        end else if (ce) begin
            if (seq_q != SEQ_RAMP && seq_q != SEQ_RUN) begin
                ls_q <= 1'b0; // [RULE9]
            end else if (v400_s) begin
                ls_q <= 1'b1; // [RULE9]
            end
        end
    end

    // ------------------------------------------------------------------
    // power state registers and shedding
    // ------------------------------------------------------------------
    pstate_t ps_a_q;
    pstate_t ps_b_q;
    logic target_ok;
    shed_t a_shed;
    shed_t b_shed;
    logic running;

    // one table serves both outputs; the second never reports four phases
    function automatic shed_t shed(input logic [2:0] cnt, input pstate_t ps);
        shed_t s;
        s.nact = cnt;
        s.overcurrent_limit = OCP_FULL;
        s.dem_ok = (ps == POWER_STATE_TWO) || (ps == POWER_STATE_THREE); // [RULE1]
        if (ps != POWER_STATE_ZERO) begin
            unique case (cnt)
                PH_FOUR: begin
                    s.nact = (ps == POWER_STATE_ONE) ? PH_TWO : PH_ONE; // [RULE12]
                    s.overcurrent_limit = (ps == POWER_STATE_ONE) ? OCP_HALF : OCP_THIRD;
                end
                PH_THREE: begin
                    s.nact = (ps == POWER_STATE_ONE) ? PH_TWO : PH_ONE; // [RULE13] [RULE16]
                    s.overcurrent_limit = (ps == POWER_STATE_ONE) ? OCP_TWO_THIRDS : OCP_THIRD;
                end
                PH_TWO: begin
                    s.nact = PH_ONE; // [RULE14] [RULE17]
                    s.overcurrent_limit = OCP_HALF;
                end
                default: begin
                    s.nact = PH_ONE; // [RULE15] [RULE18]
                    s.overcurrent_limit = OCP_FULL;
                end
            endcase
        end
        return s;
    endfunction

    assign a_shed = shed(a_cnt_q, ps_a_q); // [RULE23]
    assign b_shed = shed(b_cnt_q, ps_b_q); // [RULE23]
    assign running = (seq_q == SEQ_RAMP) || (seq_q == SEQ_RUN);
    assign target_ok = bus_sel ? b_on_q : a_on_q; // [RULE21]

    // power state writes land only on an output that is in use
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            ps_a_q <= POWER_STATE_ZERO;
            ps_b_q <= POWER_STATE_ZERO;
        end else if (ce && bus_wr && target_ok && bus_addr == ADDR_PSTATE) begin
            if (bus_sel) begin
                ps_b_q <= pstate_t'(bus_wdata[1:0]); // [RULE19] [RULE23]
            end else begin
                ps_a_q <= pstate_t'(bus_wdata[1:0]); // [RULE19] [RULE23]
            end
        end
    end

    // shedding outputs follow the table one cycle after a state change
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            a_phase_en <= '0;
            b_phase_en <= '0;
            a_overcurrent_limit <= OCP_FULL;
            b_overcurrent_limit <= OCP_FULL;
            a_diode_emulation_mode <= '0;
            b_diode_emulation_mode <= 1'b0;
        end else if (ce) begin
            a_phase_en <= (running && a_on_q) ? A_PH'((5'h01 << a_shed.nact) - 5'h01) : '0;
            b_phase_en <= (running && b_on_q) ? B_PH'((5'h01 << b_shed.nact) - 5'h01) : '0;
            a_overcurrent_limit <= a_shed.overcurrent_limit; // [RULE12]
            b_overcurrent_limit <= b_shed.overcurrent_limit; // [RULE16]
            // emulation needs the low side released, so never during diode ramp
            a_diode_emulation_mode <= {2{a_on_q && ls_q && a_shed.dem_ok && dem_sel_q}}; // [RULE2]
            b_diode_emulation_mode <= b_on_q && ls_q && b_shed.dem_ok && dem_sel_q; // [RULE2]
        end
    end

    // ------------------------------------------------------------------
    // phase clock rotation
    // ------------------------------------------------------------------
    logic a_mclk_d_q;
    logic b_mclk_d_q;
    logic [1:0] a_ptr_q;
    logic [1:0] b_ptr_q;

    // each master pulse goes to the next active phase; the pointer wraps
    // on the current count so a shed never leaves it on a dead phase
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            a_mclk_d_q <= 1'b0;
            b_mclk_d_q <= 1'b0;
            a_ptr_q <= '0;
            b_ptr_q <= '0;
            a_phase_clk <= '0;
            b_phase_clk <= '0;
        end else if (ce) begin
            a_mclk_d_q <= a_mclk_s;
            b_mclk_d_q <= b_mclk_s;
            a_phase_clk <= '0;
            b_phase_clk <= '0;
            if (!running) begin
                a_ptr_q <= '0;
                b_ptr_q <= '0;
            end else begin
                if (a_mclk_s && !a_mclk_d_q && a_on_q) begin
                    a_phase_clk <= A_PH'(4'h1 << a_ptr_q); // [RULE20]
                    a_ptr_q <= ({1'b0, a_ptr_q} + 3'h1 >= a_shed.nact) ? 2'h0 : a_ptr_q + 2'h1;
                end else if ({1'b0, a_ptr_q} >= a_shed.nact) begin
                    a_ptr_q <= '0;
                end
                if (b_mclk_s && !b_mclk_d_q && b_on_q) begin
                    b_phase_clk <= B_PH'(4'h1 << b_ptr_q); // [RULE20]
                    b_ptr_q <= ({1'b0, b_ptr_q} + 3'h1 >= b_shed.nact) ? 2'h0 : b_ptr_q + 2'h1;
                end else if ({1'b0, b_ptr_q} >= b_shed.nact) begin
                    b_ptr_q <= '0;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // register reads
    // ------------------------------------------------------------------
    assign status_rd = bus_rd && target_ok && bus_addr == ADDR_STATUS;

    // a disabled output gives neither ack nor data, as if absent
    always_ff @(posedge mclk or posedge sys_rst) begin
        if (sys_rst) begin
            bus_rdata <= RDATA_NONE;
            bus_ack <= 1'b0;
        end else if (ce) begin
            bus_rdata <= RDATA_NONE;
            bus_ack <= (bus_rd || bus_wr) && target_ok; // [RULE21]
            if (bus_rd && target_ok) begin
                if (bus_addr == ADDR_PSTATE) begin
                    bus_rdata <= DATA_W'(bus_sel ? ps_b_q : ps_a_q);
                end else if (bus_addr == ADDR_STATUS) begin
                    bus_rdata[ST_LS_BIT] <= ls_q;
                    bus_rdata[ST_PG_BIT] <= pg_q;
                    bus_rdata[ST_SEQ_HI:ST_SEQ_LO] <= seq_q;
                    bus_rdata[ST_ALERT_BIT] <= !alert_n_q;
                    bus_rdata[ST_DEM_BIT] <= dem_sel_q;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // output drive
    // ------------------------------------------------------------------
    assign power_good_output = pg_q;
    assign alert_n = alert_n_q;
    assign dac_code = dac_q;
    assign low_side_gate_en = ls_q;

endmodule

/* File: hdl/pss_pkg.sv */
// constants, codes and types for the phase shedding and start-up controller
// assumes one 200 MHz clock and one 8-bit register port shared by both regulator outputs
package pss_pkg;

    // ------------------------------------------------------------------
    // clock and timing
    // ------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    // time between two soft-start dac steps, in ns
    localparam int SS_STEP_NS = 1000;
    localparam int SS_STEP_CYC = (SS_STEP_NS * CLK_MHZ + 999) / 1000;
    localparam int SS_CNT_W = 8;

    // ------------------------------------------------------------------
    // register port
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 8;
    localparam logic [ADDR_W-1:0] ADDR_STATUS = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_PSTATE = 8'h32;
    localparam logic [DATA_W-1:0] RDATA_NONE = 8'h00;

    // status register field positions
    localparam int ST_LS_BIT = 0;
    localparam int ST_PG_BIT = 1;
    localparam int ST_SEQ_LO = 2;
    localparam int ST_SEQ_HI = 3;
    localparam int ST_ALERT_BIT = 4;
    localparam int ST_DEM_BIT = 5;

    // ------------------------------------------------------------------
    // widths, power states, phase counts
    // ------------------------------------------------------------------
    localparam int DAC_W = 8;
    localparam int A_PH = 4;
    localparam int B_PH = 3;
    localparam logic [DAC_W-1:0] DAC_ZERO = 8'h00;
    localparam logic [DAC_W-1:0] DAC_STEP = 8'h01;

    typedef enum logic [1:0] {
        POWER_STATE_ZERO = 2'h0,
        POWER_STATE_ONE = 2'h1,
        POWER_STATE_TWO = 2'h2,
        POWER_STATE_THREE = 2'h3
    } pstate_t;

    // overcurrent limit scaling codes
    typedef enum logic [1:0] {
        OCP_FULL = 2'h0,
        OCP_TWO_THIRDS = 2'h1,
        OCP_HALF = 2'h2,
        OCP_THIRD = 2'h3
    } ocp_t;

    // start-up sequencer, gray along off -> wait -> ramp -> run
    typedef enum logic [1:0] {
        SEQ_OFF = 2'h0,
        SEQ_WAIT_EN = 2'h1,
        SEQ_RAMP = 2'h3,
        SEQ_RUN = 2'h2
    } seq_t;

    localparam logic [2:0] PH_ONE = 3'h1;
    localparam logic [2:0] PH_TWO = 3'h2;
    localparam logic [2:0] PH_THREE = 3'h3;
    localparam logic [2:0] PH_FOUR = 3'h4;

    typedef struct packed {
        logic [2:0] nact;
        ocp_t overcurrent_limit;
        logic dem_ok;
    } shed_t;

endpackage

/* File: tb/pss_props.sv */
// concurrent checks on start-up, shedding and phase clock outputs
// assumes a bind onto the controller top and a single mclk domain
`timescale 1ns/1ps
module pss_props
    import pss_pkg::*;
(
    // clock and reset
    input wire logic mclk,
    input wire logic sys_rst,
    // inputs seen
    input wire logic [2:0] por_fall_ok,
    input wire logic [DAC_W-1:0] boot_voltage,
    input wire logic bus_wr,
    input wire logic bus_rd,
    // outputs watched
    input wire logic bus_ack,
    input wire logic power_good_output,
    input wire logic alert_n,
    input wire logic [DAC_W-1:0] dac_code,
    input wire logic low_side_gate_en,
    input wire logic [A_PH-1:0] a_phase_en,
    input wire logic [1:0] a_diode_emulation_mode,
    input wire logic b_diode_emulation_mode,
    input wire logic [A_PH-1:0] a_phase_clk
);
    default clocking @(posedge mclk);
    endclocking
    default disable iff (sys_rst);
    // ------------------------------------------------------------
    // start-up
    // ------------------------------------------------------------
    pg_ramp_a: assert property (
        $rose(power_good_output) |-> dac_code == DAC_ZERO) else $error("ramp not from zero");
    dac_step_a: assert property (
        power_good_output && $changed(dac_code) |-> dac_code == $past(dac_code) + DAC_STEP)
        else $error("dac step not one");
    alert_boot_a: assert property (
        $fell(alert_n) |-> power_good_output && dac_code == boot_voltage)
        else $error("alert before boot level");
    // sync plus sequencer latency gives the supply drop six cycles to act
    supply_off_a: assert property (
        (por_fall_ok != 3'h7) [*6] |-> !power_good_output && a_phase_en == 4'h0)
        else $error("running without supplies");
    // low side clears one stage after power good drops
    ls_gate_a: assert property (
        low_side_gate_en |-> power_good_output || $past(power_good_output))
        else $error("low side outside ramp");
    // ------------------------------------------------------------
    // shedding, emulation, clocks, bus
    // ------------------------------------------------------------
    // emulation may lag the low-side release by one register stage
    a_dem_a: assert property (
        a_diode_emulation_mode != 2'h0 |-> a_diode_emulation_mode == 2'h3
        && (low_side_gate_en || $past(low_side_gate_en))) else $error("bad emulation");
    b_dem_a: assert property (
        b_diode_emulation_mode |-> low_side_gate_en || $past(low_side_gate_en))
        else $error("b emulation early");
    thermo_mask_a: assert property (
        a_phase_en inside {4'h0, 4'h1, 4'h3, 4'h7, 4'hF}) else $error("mask not thermometer");
    clk_rotate_a: assert property (
        $onehot0(a_phase_clk) && (a_phase_clk & ~a_phase_en & ~$past(a_phase_en)) == 4'h0)
        else $error("clock to idle phase");
    ack_cause_a: assert property (
        bus_ack |-> $past(bus_wr || bus_rd)) else $error("ack without strobe");
endmodule

/* File: tb/host_model.sv */
// host side of the register port: one-cycle strobes, answer next cycle
// assumes the bench calls its task from one process at a time
`timescale 1ns/1ps
module host_model
    import pss_pkg::*;
(
    // clock
    input wire logic mclk,
    // register port
    output logic bus_sel = 1'b0,
    output logic [ADDR_W-1:0] bus_addr = 8'h00,
    output logic [DATA_W-1:0] bus_wdata = 8'h00,
    output logic bus_wr = 1'b0,
    output logic bus_rd = 1'b0,
    input wire logic [DATA_W-1:0] bus_rdata,
    input wire logic bus_ack
);
    // one access; address and data inverted after so stale values never help
    task automatic xfer(input logic sel, input logic wr, input logic [ADDR_W-1:0] a,
            input logic [DATA_W-1:0] d, output logic [DATA_W-1:0] q, output logic ack);
        @(posedge mclk);
        bus_sel <= sel;
        bus_addr <= a;
        bus_wdata <= d;
        bus_wr <= wr;
        bus_rd <= !wr;
        @(posedge mclk);
        bus_wr <= 1'b0;
        bus_rd <= 1'b0;
        bus_addr <= ~a;
        bus_wdata <= ~d;
        #1;
        q = bus_rdata;
        ack = bus_ack;
    endtask
endmodule

/* File: tb/tb_top.sv */
// bench: boots four strap sets and walks every power state on both outputs
// assumes the host model on the register port and the bound checker
`timescale 1ns/1ps
module tb_top
    import pss_pkg::*;
;
    logic mclk, sys_rst = 1'b1, ce = 1'b1, rgen = 1'b0, vout = 1'b1, spr = 1'b0, amc = 1'b0;
    logic [2:0] por = 3'h0;
    logic [DAC_W-1:0] bootv = 8'h02, dac;
    logic [A_PH-1:0] a_s = 4'h0, a_en, a_clk;
    logic [B_PH-1:0] b_s = 3'h0, b_en, b_clk;
    logic [1:0] a_oc, b_oc, a_dem;
    logic b_dem, bsel, bwr, brd, ack, pg, aln, ls;
    logic [7:0] addr, wd, rdata;
    int bad_count = 0;
    int check_count = 0;
    int cyc = 0;
    // ------------------------------------------------------------
    // clock, master one-shots, instances
    // ------------------------------------------------------------
    initial begin
        mclk = 1'b0;
        forever #2.5 mclk = ~mclk;
    end
    // short master pulse every 40 cycles feeds both master clock inputs
    always @(posedge mclk) begin
        cyc <= cyc + 1;
        amc <= (cyc % 40) < 3;
    end
    phase_shedding_startup_control dut_u (.mclk(mclk), .sys_rst(sys_rst), .ce(ce),
        .por_rise_ok(por), .por_fall_ok(por), .regulator_enable_input(rgen),
        .vout_above_400mv(vout), .boot_voltage(bootv), .second_program_resistor(spr),
        .a_phase_sense_pin(a_s), .b_phase_sense_pin(b_s), .a_master_clk(amc), .b_master_clk(amc),
        .bus_sel(bsel), .bus_addr(addr), .bus_wdata(wd), .bus_wr(bwr), .bus_rd(brd),
        .bus_rdata(rdata), .bus_ack(ack), .power_good_output(pg), .alert_n(aln),
        .dac_code(dac), .low_side_gate_en(ls), .a_phase_en(a_en), .b_phase_en(b_en),
        .a_overcurrent_limit(a_oc), .b_overcurrent_limit(b_oc), .a_diode_emulation_mode(a_dem),
        .b_diode_emulation_mode(b_dem), .a_phase_clk(a_clk), .b_phase_clk(b_clk));
    host_model host_u (.mclk(mclk), .bus_sel(bsel), .bus_addr(addr), .bus_wdata(wd),
        .bus_wr(bwr), .bus_rd(brd), .bus_rdata(rdata), .bus_ack(ack));
    // ------------------------------------------------------------
    // helpers
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        check_count++;
        if (got !== exp) begin
            bad_count++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    // expected {phase mask, overcurrent code} for n phases in state ps
    function automatic logic [5:0] exp_shed(input int n, input int ps);
        int m;
        logic [1:0] oc;
        m = (ps == 0) ? n : (ps == 1 && n > 2) ? 2 : 1;
        oc = (n == 1 || ps == 0) ? OCP_FULL : (ps == 1) ? ((n == 3) ? OCP_TWO_THIRDS : OCP_HALF)
            : ((n == 2) ? OCP_HALF : OCP_THIRD);
        return {4'((1 << m) - 1), oc};
    endfunction
    task automatic stop_test();
        $display("checks %0d mismatches %0d", check_count, bad_count);
        if (bad_count == 0 && check_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------
    // supply loss, restrap, start-up ramp; enable held high on later runs
    task automatic t_boot(input int n);
        logic [DATA_W-1:0] q;
        logic k;
        @(posedge mclk);
        por <= 3'h0;
        rgen <= n > 0;
        repeat (8) @(posedge mclk);
        chk({pg, ls, a_en}, 16'h0000);
        a_s <= 4'hF << (4 - n);
        b_s <= (n == 3) ? 3'h1 : 3'h7 << (3 - n);
        spr <= n[0];
        @(posedge mclk);
        por <= 3'h7;
        if (n == 0) begin
            repeat (10) @(posedge mclk);
            chk(pg, 1'b0);
            rgen <= 1'b1;
        end
        for (int i = 0; i < 12 && pg !== 1'b1; i++) @(posedge mclk);
        #1;
        chk({pg, dac}, {1'b1, DAC_ZERO});
        for (int i = 0; i < 1000 && aln !== 1'b0; i++) @(posedge mclk);
        #1;
        chk({aln, dac}, {1'b0, bootv});
        host_u.xfer(1'b0, 1'b0, ADDR_STATUS, 8'h00, q, k);
        chk({k, q[ST_PG_BIT], aln}, 16'h0007);
    endtask
    // every power state on both outputs, emulation choice alternating per run
    task automatic t_shed(input int n);
        logic [DATA_W-1:0] q;
        logic k;
        for (int ps = 0; ps < 4; ps++) begin
            host_u.xfer(1'b0, 1'b1, ADDR_PSTATE, {6'h3F, ps[1:0]}, q, k);
            chk(k, 1'b1);
            host_u.xfer(1'b1, 1'b1, ADDR_PSTATE, {6'h00, ps[1:0]}, q, k);
            chk(k, n < 3);
            repeat (2) @(posedge mclk);
            #1;
            chk({a_en, a_oc}, exp_shed(4 - n, ps));
            chk(a_dem, {2{ps > 1 && spr}});
            if (n < 3) begin
                chk({b_en, b_oc}, exp_shed(3 - n, ps));
                chk(b_dem, ps > 1 && spr);
            end
        end
        chk(ls, 1'b1);
    endtask
    // main sequence
    initial begin
        repeat (20) @(posedge mclk);
        sys_rst <= 1'b0;
        for (int n = 0; n < 4; n++) begin
            t_boot(n);
            t_shed(n);
            $display("strap set %0d done", n);
        end
        stop_test();
    end
    // watchdog at five times the expected length
    initial begin
        repeat (10000) @(posedge mclk);
        bad_count++;
        stop_test();
    end
endmodule
bind phase_shedding_startup_control pss_props props_u (.*);
